/* File: design/elpm_regs.sv */
// Register bank: program word 15 bytes and read-only engine map registers
`timescale 1ns/10ps
`default_nettype none

module elpm_regs
   import elpm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Write request and read address
   input wire elpm_req_s req,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rdata,
   // Engine assignment state
   input wire elpm_map_s eng_map [ENG_N],
   // Program word 15
   output logic [7:0] instr_word15_hi,
   output logic [7:0] instr_word15_lo
);

   // ==========================================================
   // Program word storage
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   wire hit_hi = req.wr && (req.addr == OFS_WORD15_HI);
   wire hit_lo = req.wr && (req.addr == OFS_WORD15_LO);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         hi_q <= REG_RESET;
      else if (hit_hi)
         hi_q <= req.wdata;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         lo_q <= REG_RESET;
      else if (hit_lo)
         lo_q <= req.wdata;
   end

   assign instr_word15_hi = hi_q;
   assign instr_word15_lo = lo_q;

   // ==========================================================
   // Engine map capture
   // Captured only from the engines, so a host write never reaches it
   elpm_map_s map_q [ENG_N];
   logic [7:0] upper [ENG_N];
   logic [7:0] lower [ENG_N];

   genvar g;
   generate
      for (g = 0; g < ENG_N; g++)
      begin : g_eng
         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
               map_q[g] <= '0;
            else
               map_q[g] <= eng_map[g];
         end
         assign upper[g] = (8'(map_q[g].fader_on) << FADER_POS)
                         | (8'(map_q[g].has_ch[CH8_IDX]) << CH8_POS);
         assign lower[g] = map_q[g].has_ch[7:0];
      end
   endgenerate

   // ==========================================================
   // Read selection
   assign rdata = (rd_addr == OFS_WORD15_HI) ? hi_q :
                  (rd_addr == OFS_WORD15_LO) ? lo_q :
                  (rd_addr == OFS_ENG1_UPPER) ? upper[0] :
                  (rd_addr == OFS_ENG1_LOWER) ? lower[0] :
                  (rd_addr == OFS_ENG2_UPPER) ? upper[1] :
                  (rd_addr == OFS_ENG2_LOWER) ? lower[1] : UNMAPPED_READ;

endmodule
`default_nettype wire

/* File: design/elpm_top.sv */
// Serial control bus slave in front of the engine map and program word bank
//
// Contract
// - Offset 6E holds word 15 high byte, read/write, resets zero.
// - Offset 6F holds word 15 low byte, read/write, resets zero.
// - Offset 70 bit 1 shows engine one fader enable, resets zero.
// - Offset 70 bit 0 shows channel 8 on engine one; rest zero.
// - Offset 71 bit n shows channel n assigned to engine one.
// - Offset 72 bit 1 shows engine two fader enable, resets zero.
// - Offset 72 bit 0 shows channel 8 on engine two; rest zero.
// - Offset 73 bit n shows channel n assigned to engine two.
`timescale 1ns/10ps
`default_nettype none

module elpm_top
   import elpm_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial bus pins, data is open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Engine assignment state
   input wire elpm_map_s eng_map [ENG_N],
   // Program word 15
   output logic [7:0] instr_word15_hi,
   output logic [7:0] instr_word15_lo
);

   // ==========================================================
   // Pin synchronisers
   // First stage feeds only the second; edges use stages two and three
   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
      end
      else
      begin
         scl_m_q <= scl_i;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   // ==========================================================
   // Bus conditions
   wire scl_rise = scl_s_q & ~scl_p_q;
   wire scl_fall = ~scl_s_q & scl_p_q;
   wire scl_high = scl_s_q & scl_p_q;
   wire start_det = scl_high & sda_p_q & ~sda_s_q;
   wire stop_det = scl_high & ~sda_p_q & sda_s_q;

   // ==========================================================
   // Slave state
   elpm_state_e state_q;
   elpm_state_e state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic rw_q;
   logic rw_d;
   logic nack_q;
   logic nack_d;
   logic drive_q;
   logic drive_d;
   logic wr_en;
   logic [7:0] rdata;
   elpm_req_s req;

   wire byte_done = (cnt_q == BITS_PER_BYTE);
   wire addr_match = (shift_q[7:1] == DEV_ADDR);
   wire [3:0] cnt_inc = 4'(cnt_q + BIT_CNT_STEP);
   wire [7:0] ptr_inc = 8'(ptr_q + PTR_STEP);
   wire [7:0] shift_in = {shift_q[6:0], sda_s_q};
   wire [7:0] shift_out = {shift_q[6:0], 1'b0};

   assign req.wr = wr_en;
   assign req.addr = ptr_q;
   assign req.wdata = shift_q;

   // ==========================================================
   // Next state
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      nack_d = nack_q;
      drive_d = drive_q;
      wr_en = 1'b0;
      if (stop_det)
      begin
         state_d = ST_IDLE;
         drive_d = 1'b0;
      end
      else if (start_det)
      begin
         state_d = ST_ADDR;
         cnt_d = BIT_CNT_RESET;
         drive_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               drive_d = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA:
            begin
               if (scl_rise)
               begin
                  shift_d = shift_in;
                  cnt_d = cnt_inc;
               end
               else if (scl_fall && byte_done)
               begin
                  cnt_d = BIT_CNT_RESET;
                  if (state_q == ST_ADDR)
                  begin
                     // Another device's address: stay silent until next start
                     if (addr_match)
                     begin
                        rw_d = shift_q[0];
                        drive_d = 1'b1;
                        state_d = ST_ADDR_ACK;
                     end
                     else
                     begin
                        state_d = ST_IDLE;
                     end
                  end
                  else if (state_q == ST_PTR)
                  begin
                     ptr_d = shift_q;
                     drive_d = 1'b1;
                     state_d = ST_PTR_ACK;
                  end
                  else
                  begin
                     // write goes to the bank decode
                     wr_en = 1'b1;
                     ptr_d = ptr_inc;
                     drive_d = 1'b1;
                     state_d = ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_d = BIT_CNT_RESET;
                  if (rw_q)
                  begin
                     shift_d = rdata;
                     drive_d = ~rdata[7];
                     ptr_d = ptr_inc;
                     state_d = ST_RDATA;
                  end
                  else
                  begin
                     drive_d = 1'b0;
                     state_d = ST_PTR;
                  end
               end
            end
            ST_PTR_ACK, ST_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  drive_d = 1'b0;
                  cnt_d = BIT_CNT_RESET;
                  state_d = ST_WDATA;
               end
            end
            ST_RDATA:
            begin
               if (scl_rise)
               begin
                  cnt_d = cnt_inc;
               end
               else if (scl_fall)
               begin
                  if (byte_done)
                  begin
                     drive_d = 1'b0;
                     state_d = ST_RD_ACK;
                  end
                  else
                  begin
                     shift_d = shift_out;
                     drive_d = ~shift_q[6];
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
               begin
                  nack_d = sda_s_q;
               end
               else if (scl_fall)
               begin
                  cnt_d = BIT_CNT_RESET;
                  if (nack_q)
                  begin
                     state_d = ST_IDLE;
                  end
                  else
                  begin
                     shift_d = rdata;
                     drive_d = ~rdata[7];
                     ptr_d = ptr_inc;
                     state_d = ST_RDATA;
                  end
               end
            end
            default:
            begin
               state_d = ST_IDLE;
               drive_d = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= BIT_CNT_RESET;
         shift_q <= REG_RESET;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ptr_q <= REG_RESET;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         drive_q <= 1'b0;
      end
      else
      begin
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         drive_q <= drive_d;
      end
   end

   // ==========================================================
   // Open drain data pin
   // Only ever pulls low; high comes from the bus pull-up
   assign sda_o = 1'b0;
   assign sda_oe_n = ~drive_q;

   // ==========================================================
   // Register bank
   elpm_regs i_elpm_regs (
      .clk(clk),
      .nrst(nrst),
      .req(req),
      .rd_addr(ptr_q),
      .rdata(rdata),
      .eng_map(eng_map),
      .instr_word15_hi(instr_word15_hi),
      .instr_word15_lo(instr_word15_lo)
   );

endmodule
`default_nettype wire

/* File: include/elpm_pkg.sv */
// Constants and types shared by the engine map and program word register bank
`default_nettype none

package elpm_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CHAN_N = 9;
   localparam int unsigned ENG_N = 2;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_WORD15_HI = 8'h6E;
   localparam logic [7:0] OFS_WORD15_LO = 8'h6F;
   localparam logic [7:0] OFS_ENG1_UPPER = 8'h70;
   localparam logic [7:0] OFS_ENG1_LOWER = 8'h71;
   localparam logic [7:0] OFS_ENG2_UPPER = 8'h72;
   localparam logic [7:0] OFS_ENG2_LOWER = 8'h73;

   // ==========================================================
   // Reset values and field positions
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int unsigned FADER_POS = 1;
   localparam int unsigned CH8_POS = 0;
   localparam int unsigned CH8_IDX = 8;

   // ==========================================================
   // Serial bus constants
   // Arbitrary neutral value, not tied to any product
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;
   localparam logic [3:0] BIT_CNT_STEP = 4'h1;
   localparam logic [7:0] PTR_STEP = 8'h01;

   // ==========================================================
   // Types
   typedef struct packed {
      logic fader_on;
      logic [CHAN_N-1:0] has_ch;
   } elpm_map_s;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } elpm_req_s;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_PTR = 9'h008,
      ST_PTR_ACK = 9'h010,
      ST_WDATA = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA = 9'h080,
      ST_RD_ACK = 9'h100
   } elpm_state_e;

endpackage

`default_nettype wire

/* File: tb/elpm_checker.sv */
// Checker on the pins of the serial slave and program word outputs
`timescale 1ns/10ps
`default_nettype none

module elpm_checker
   import elpm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   // Program word 15
   input wire logic [7:0] instr_word15_hi,
   input wire logic [7:0] instr_word15_lo
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // ========
   // Properties
   property p_hi_rst;
      $rose(nrst) |-> instr_word15_hi == REG_RESET;
   endproperty
   a_hi_rst: assert property (p_hi_rst)
      else $error("word hi not zero after reset");
   property p_lo_rst;
      $rose(nrst) |-> instr_word15_lo == REG_RESET;
   endproperty
   a_lo_rst: assert property (p_lo_rst)
      else $error("word lo not zero after reset");
   // Writes land only after a synced clock fall, never with clock high
   property p_hi_scl;
      !$stable(instr_word15_hi) |-> !scl_i && !$past(scl_i, 3);
   endproperty
   a_hi_scl: assert property (p_hi_scl)
      else $error("word hi changed outside a write slot");
   property p_lo_scl;
      !$stable(instr_word15_lo) |-> !scl_i && !$past(scl_i, 3);
   endproperty
   a_lo_scl: assert property (p_lo_scl)
      else $error("word lo changed outside a write slot");
   property p_one;
      !$stable(instr_word15_lo) |-> $stable(instr_word15_hi);
   endproperty
   a_one: assert property (p_one)
      else $error("both bytes changed together");
   property p_oe_rst;
      $rose(nrst) |-> sda_oe_n;
   endproperty
   a_oe_rst: assert property (p_oe_rst)
      else $error("data line pulled after reset");
   property p_oe_scl;
      $changed(sda_oe_n) |-> !scl_i && !$past(scl_i, 3);
   endproperty
   a_oe_scl: assert property (p_oe_scl)
      else $error("data line moved with clock high");
   property p_sda_o;
      sda_o == 1'h0;
   endproperty
   a_sda_o: assert property (p_sda_o)
      else $error("data output not low");
   // A stored byte always comes with the device pulling the acknowledge
   property p_hi_ack;
      !$stable(instr_word15_hi) |-> !sda_oe_n;
   endproperty
   a_hi_ack: assert property (p_hi_ack)
      else $error("word hi changed without an acknowledge");
   property p_lo_ack;
      !$stable(instr_word15_lo) |-> !sda_oe_n;
   endproperty
   a_lo_ack: assert property (p_lo_ack)
      else $error("word lo changed without an acknowledge");

   // ========
   // Coverage
   c_hi: cover property (!$stable(instr_word15_hi));
   c_lo: cover property (!$stable(instr_word15_lo));
   c_ack: cover property ($fell(sda_oe_n));
endmodule

bind elpm_top elpm_checker i_elpm_checker (.clk(clk), .nrst(nrst), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .instr_word15_hi(instr_word15_hi),
   .instr_word15_lo(instr_word15_lo));

`default_nettype wire

/* File: tb/elpm_host.sv */
// Serial bus host model driving the clock and the open-drain data line
`timescale 1ns/10ps
`default_nettype none

module elpm_host
   import elpm_pkg::*;
#(
   parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT
)
(
   // Clock
   input wire logic clk,
   // Bus pins
   input wire logic sda_oe_n,
   output logic scl,
   output logic sda
);
   logic sda_m = 1'h1;

   // ========
   // Wire with pull-up, low when either side pulls
   assign sda = sda_m & sda_oe_n;
   initial scl = 1'h1;

   // ========
   // Bit and frame tasks, 12 clk per clock phase
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task xb(input logic b, output logic r);
      sda_m <= b;
      wt(6);
      scl <= 1'h1;
      wt(12);
      r = sda;
      scl <= 1'h0;
      wt(6);
   endtask
   task xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      for (int i = 7; i >= 0; i--) xb(d[i], q[i]);
      xb(a, r);
   endtask
   task start();
      sda_m <= 1'h1;
      wt(6);
      scl <= 1'h1;
      wt(6);
      sda_m <= 1'h0;
      wt(12);
      scl <= 1'h0;
      wt(6);
   endtask
   task stop();
      sda_m <= 1'h0;
      wt(6);
      scl <= 1'h1;
      wt(6);
      sda_m <= 1'h1;
      wt(12);
   endtask
   // Nak is set when any byte went unacknowledged
   task wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xbyte({ADDR, 1'h0}, 1'h1, q, a0);
      xbyte(p, 1'h1, q, a1);
      xbyte(d, 1'h1, q, a2);
      stop();
      nak = a0 | a1 | a2;
   endtask
   // Pointer write, repeated start, one byte ended by a nack
   task rd(input logic [7:0] p, output logic [7:0] v);
      logic [7:0] q;
      logic a;
      start();
      xbyte({ADDR, 1'h0}, 1'h1, q, a);
      xbyte(p, 1'h1, q, a);
      start();
      xbyte({ADDR, 1'h1}, 1'h1, q, a);
      xbyte(8'hFF, 1'h1, v, a);
      stop();
   endtask
   // Two data bytes from pointer p to bus address s, nak as in wr
   task wr2(input logic [6:0] s, input logic [7:0] p, input logic [7:0] d0,
      input logic [7:0] d1, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start();
      xbyte({s, 1'h0}, 1'h1, q, a0);
      xbyte(p, 1'h1, q, a1);
      xbyte(d0, 1'h1, q, a2);
      xbyte(d1, 1'h1, q, a3);
      stop();
      nak = a0 | a1 | a2 | a3;
   endtask
   // Pointer write, repeated start, two bytes with a host ack between
   task rd2(input logic [7:0] p, output logic [7:0] v0, output logic [7:0] v1);
      logic [7:0] q;
      logic a;
      start();
      xbyte({ADDR, 1'h0}, 1'h1, q, a);
      xbyte(p, 1'h1, q, a);
      start();
      xbyte({ADDR, 1'h1}, 1'h1, q, a);
      xbyte(8'hFF, 1'h0, v0, a);
      xbyte(8'hFF, 1'h1, v1, a);
      stop();
   endtask
endmodule

`default_nettype wire

/* File: tb/elpm_top_tb.sv */
// Testbench for the engine map and program word register bank
`timescale 1ns/10ps
`default_nettype none

module elpm_top_tb
   import elpm_pkg::*;
;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic scl;
   logic sda;
   logic sda_o;
   logic sda_oe_n;
   elpm_map_s eng_map [ENG_N] = '{default: '0};
   logic [7:0] hi;
   logic [7:0] lo;
   logic [7:0] v;
   logic [7:0] v1;
   logic nak;
   int bad_count = 0;
   int samples_checked = 0;
   // Fader and channel 8 in the top two bits, channels 7..0 below
   logic [9:0] pat [6] = '{10'h355, 10'h0AA, 10'h1FF, 10'h300, 10'h201, 10'h080};

   initial forever #2.5 clk = ~clk;

   elpm_top i_elpm_top (.clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .eng_map(eng_map), .instr_word15_hi(hi), .instr_word15_lo(lo));
   elpm_host i_elpm_host (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

   // ========
   // Compare and verdict
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task report_and_stop();
      if (bad_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task rchk(input string n, input logic [7:0] p, input logic [7:0] e);
      i_elpm_host.rd(p, v);
      chk(n, e, v);
   endtask
   task mapchk(input int k);
      rchk("eng1 upper", OFS_ENG1_UPPER, {6'h00, pat[2*k][9:8]});
      rchk("eng1 lower", OFS_ENG1_LOWER, pat[2*k][7:0]);
      rchk("eng2 upper", OFS_ENG2_UPPER, {6'h00, pat[2*k+1][9:8]});
      rchk("eng2 lower", OFS_ENG2_LOWER, pat[2*k+1][7:0]);
   endtask

   // ========
   // Tests
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'h1;
      repeat (5) @(posedge clk);
      chk("word hi out", 8'h00, hi);
      chk("word lo out", 8'h00, lo);
      for (int k = 0; k < 6; k++) rchk("reset read", 8'(OFS_WORD15_HI + k), 8'h00);
      i_elpm_host.wr(OFS_WORD15_HI, 8'hA5, nak);
      chk("hi ack", 8'h00, {7'h00, nak});
      i_elpm_host.wr(OFS_WORD15_LO, 8'h3C, nak);
      chk("word hi out", 8'hA5, hi);
      chk("word lo out", 8'h3C, lo);
      rchk("hi read", OFS_WORD15_HI, 8'hA5);
      rchk("lo read", OFS_WORD15_LO, 8'h3C);
      for (int k = 0; k < 3; k++)
      begin
         eng_map[0] <= pat[2*k];
         eng_map[1] <= pat[2*k+1];
         mapchk(k);
      end
      // Map registers must ignore host writes
      for (int k = 2; k < 6; k++) i_elpm_host.wr(8'(OFS_WORD15_HI + k), 8'hFF, nak);
      chk("map write ack", 8'h00, {7'h00, nak});
      mapchk(2);
      chk("word hi kept", 8'hA5, hi);
      chk("word lo kept", 8'h3C, lo);
      rchk("unmapped", 8'h50, UNMAPPED_READ);
      // A second reset in mid-run clears both bytes
      nrst <= 1'h0;
      repeat (5) @(posedge clk);
      nrst <= 1'h1;
      repeat (5) @(posedge clk);
      chk("word hi reset", 8'h00, hi);
      chk("word lo reset", 8'h00, lo);
      // Foreign bus address gets no acknowledge and writes nothing
      i_elpm_host.wr2(DEV_ADDR_DEFAULT ^ 7'h01, OFS_WORD15_HI, 8'h11, 8'h22, nak);
      chk("foreign nak", 8'h01, {7'h00, nak});
      chk("word hi foreign", 8'h00, hi);
      chk("word lo foreign", 8'h00, lo);
      // Two-byte write and read walk the pointer from 6E to 6F
      i_elpm_host.wr2(DEV_ADDR_DEFAULT, OFS_WORD15_HI, 8'h5A, 8'hC3, nak);
      chk("burst ack", 8'h00, {7'h00, nak});
      chk("burst hi out", 8'h5A, hi);
      chk("burst lo out", 8'hC3, lo);
      i_elpm_host.rd2(OFS_WORD15_HI, v, v1);
      chk("burst hi read", 8'h5A, v);
      chk("burst lo read", 8'hC3, v1);
      report_and_stop();
   end

   // Hang guard, about two and a half times the expected run
   initial
   begin
      #400us;
      bad_count++;
      report_and_stop();
   end
endmodule

`default_nettype wire
